// *** lsc_assertions.sv ***
`timescale 1ns/1ps
module lsc_chk #(
  parameter int AZ_CYCLES = lsc_pkg::AZ_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic sample_valid,
  input wire lsc_pkg::lsc_sample_t sample,
  input wire lsc_pkg::lsc_sensor_t sensor,
  input wire logic reset_btn,
  input wire logic [3:0] contact,
  input wire logic irq
);
  logic [2:0] quiet_q;
  wire rd_take = hsel & htrans[1] & hready & !hwrite;
  wire wr_take = hsel & htrans[1] & hready & hwrite;
  wire odd_addr = (haddr[1:0] != 2'h0) || (haddr[31:8] != 24'h0) || (haddr[7:0] >= 8'h4c);
  // Cycles since anything that may move a contact; saturates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) quiet_q <= 3'h0;
    else if (sample_valid | reset_btn | wr_take | $changed(sensor)) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_fast: assert property (wr_take |=> hreadyout)
    else $error("write stalled");
  a_rdy_one: assert property (!hreadyout |=> hreadyout)
    else $error("ready low too long");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  a_rd_zero: assert property (rd_take && odd_addr |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_contact_quiet: assert property (quiet_q >= 3'h4 |-> $stable(contact))
    else $error("contact moved without cause");
  a_reset_open: assert property ($rose(hresetn) |-> contact == 4'h0 && !irq)
    else $error("outputs not idle after reset");
  c_trip: cover property (sample_valid ##1 $changed(contact));
  c_irq: cover property ($rose(irq));
  c_read: cover property (rd_take ##2 hreadyout);
endmodule
bind lsc_top lsc_chk #(.AZ_CYCLES(AZ_CYCLES)) i_chk (.*);

// *** lsc_pkg.sv ***
package lsc_pkg;

  localparam int NUM_LIM = 4;
  localparam int NUM_CHAN = 2;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_SET0 = 8'h10;
  localparam logic [7:0] ADDR_RST0 = 8'h20;
  localparam logic [7:0] ADDR_CPI = 8'h30;
  localparam logic [7:0] ADDR_AZ_EN = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h3c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h40;
  localparam logic [7:0] ADDR_TARE_A = 8'h44;
  localparam logic [7:0] ADDR_TARE_B = 8'h48;
  localparam logic [7:0] ADDR_CMD = 8'h4c;

  // Reset values
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [31:0] POINT_RESET = 32'h00000000;
  localparam logic [31:0] CPI_RESET = 32'h00005dc0;
  localparam logic [31:0] TARE_RESET = 32'h00000000;

  // Limit sources
  localparam logic [3:0] SRC_LOAD = 4'h0;
  localparam logic [3:0] SRC_PEAK = 4'h1;
  localparam logic [3:0] SRC_VALLEY = 4'h2;
  localparam logic [3:0] SRC_POS = 4'h3;
  localparam logic [3:0] SRC_VEL = 4'h4;
  localparam logic [3:0] SRC_GROSS = 4'h5;
  localparam logic [3:0] SRC_SUM = 4'h6;
  localparam logic [3:0] SRC_POLY = 4'h7;
  localparam logic [3:0] SRC_AVG = 4'h8;

  // Status and interrupt field positions
  localparam int STAT_ACT_LSB = 0;
  localparam int STAT_ERR_LSB = 4;
  localparam int IRQ_TRIP_LSB = 0;
  localparam int IRQ_ERR_LSB = 4;
  localparam int IRQ_AZ_LSB = 8;
  localparam int IRQ_W = 10;

  // Auto-zero band and hold time
  localparam logic signed [31:0] AZ_BAND = 32'sh0000000a;
  localparam int AZ_TIME_S = 10;
  localparam int CLK_HZ = 50_000_000;
  localparam int AZ_CYCLES = AZ_TIME_S * CLK_HZ;

  typedef struct packed {
    logic [3:0] src;
    logic chan_b;
    logic latch;
    logic trip_below;
    logic enable;
    logic default_nc;
  } lsc_cfg_t;

  typedef struct packed {
    logic signed [31:0] load_a_raw;
    logic signed [31:0] load_b_raw;
    logic signed [31:0] peak;
    logic signed [31:0] valley;
    logic signed [31:0] position;
    logic signed [31:0] velocity;
    logic signed [31:0] gross;
    logic signed [31:0] poly;
    logic signed [31:0] avg;
  } lsc_sample_t;

  typedef struct packed {
    logic [1:0] calibrated;
    logic [1:0] rating_zero;
    logic [1:0] mvv_zero;
  } lsc_sensor_t;

endpackage

// *** lsc_relay.sv ***
`timescale 1ns/1ps
// Equipment on the contacts; remembers which contacts ever closed
module lsc_relay (
  input wire logic hclk,
  input wire logic [3:0] contact,
  output logic [3:0] closed_seen
);
  // Plain always, since the initial block also writes this variable
  initial closed_seen = 4'h0;
  always @(posedge hclk) closed_seen <= closed_seen | contact;
endmodule

// *** lsc_top.sv ***
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - Four independent limiters, each with its own contact output, indexed zero to three.
// - Each limiter has a default contact state, normally open or normally closed.
// - Disabled limiter holds default contact state; other settings ignored.
// - Enabled limiter compares one selectable source in chosen units.
// - Trip-above activates when source exceeds set point.
// - Trip-below activates when source drops under set point.
// - Non-latching trip-above deactivates when source falls below reset point.
// - Non-latching trip-below deactivates when source rises above reset point.
// - Latching limiter stays active until manual reset; reset point unused.
// - Set and reset evaluated separately; reset wins when both true.
// - Source error forces output off as if disabled.
// - Enabled limiter with source error is flagged in limit status.
// - Error: uncalibrated load, zero rating, zero mV/V, or zero counts per inch.
// - Per-channel auto-zero enable for channels A and B.
// - Auto-zero tares load held within 10 counts of zero for 10 seconds.
// - Encoder counts-per-inch setting, reset value 24000.
module lsc_top #(
  parameter int AZ_CYCLES = lsc_pkg::AZ_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic sample_valid,
  input wire lsc_pkg::lsc_sample_t sample,
  input wire lsc_pkg::lsc_sensor_t sensor,
  input wire logic reset_btn,
  output logic [3:0] contact,
  output logic irq
);

  localparam int NL = lsc_pkg::NUM_LIM;
  localparam int NC = lsc_pkg::NUM_CHAN;

  // Bus state
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic addr_ok_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;

  // Register file
  logic [8:0] ctrl_q [NL];
  logic signed [31:0] set_q [NL];
  logic signed [31:0] rst_q [NL];
  logic [31:0] cpi_q;
  logic [NC-1:0] az_en_q;
  logic [lsc_pkg::IRQ_W-1:0] irq_stat_q;
  logic [lsc_pkg::IRQ_W-1:0] irq_mask_q;
  logic signed [31:0] tare_q [NC];

  // Limiter state
  logic [NL-1:0] act_q;
  logic [NL-1:0] act_d;
  logic [NL-1:0] err_q;
  logic [NL-1:0] err_d;
  logic [3:0] contact_q;
  logic [3:0] contact_d;
  logic irq_q;
  logic [NC-1:0] az_fire;
  logic signed [31:0] net_load [NC];

  // Address phase and decode
  wire ap = hsel & htrans[1] & hready;
  wire we = wr_pend_q & addr_ok_q;
  wire [1:0] idx = addr_q[3:2];
  wire sel_ctrl = addr_q[7:4] == 4'h0;
  wire sel_set = addr_q[7:4] == 4'h1;
  wire sel_rst = addr_q[7:4] == 4'h2;
  wire sel_cpi = addr_q == lsc_pkg::ADDR_CPI;
  wire sel_az = addr_q == lsc_pkg::ADDR_AZ_EN;
  wire sel_stat = addr_q == lsc_pkg::ADDR_STATUS;
  wire sel_istat = addr_q == lsc_pkg::ADDR_IRQ_STAT;
  wire sel_imask = addr_q == lsc_pkg::ADDR_IRQ_MASK;
  wire sel_tare_a = addr_q == lsc_pkg::ADDR_TARE_A;
  wire sel_tare_b = addr_q == lsc_pkg::ADDR_TARE_B;
  wire sel_cmd = addr_q == lsc_pkg::ADDR_CMD;
  wire [NL-1:0] cmd_clr = (we & sel_cmd) ? hwdata[NL-1:0] : '0;

  wire [31:0] status_word = {24'h000000, err_q, act_q};

  wire [31:0] rdata =
    !addr_ok_q ? 32'h00000000 :
    sel_ctrl ? {23'h000000, ctrl_q[idx]} :
    sel_set ? set_q[idx] :
    sel_rst ? rst_q[idx] :
    sel_cpi ? cpi_q :
    sel_az ? {30'h00000000, az_en_q} :
    sel_stat ? status_word :
    sel_istat ? {22'h000000, irq_stat_q} :
    sel_imask ? {22'h000000, irq_mask_q} :
    sel_tare_a ? tare_q[0] :
    sel_tare_b ? tare_q[1] :
    32'h00000000;

  // Reads take one wait state so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      addr_ok_q <= 1'b0;
      hreadyout_q <= 1'b1;
    end else begin
      wr_pend_q <= ap & hwrite;
      rd_pend_q <= ap & ~hwrite;
      hreadyout_q <= ~(ap & ~hwrite);
      if (ap) begin
        addr_q <= haddr[7:0];
        addr_ok_q <= (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_pend_q) begin
      hrdata_q <= rdata;
    end
  end

  // Limiter configuration and points
  generate
    for (genvar i = 0; i < NL; i++) begin : g_regs
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ctrl_q[i] <= lsc_pkg::CTRL_RESET;
          set_q[i] <= lsc_pkg::POINT_RESET;
          rst_q[i] <= lsc_pkg::POINT_RESET;
        end else begin
          if (we && sel_ctrl && idx == 2'(i)) begin
            ctrl_q[i] <= hwdata[8:0];
          end
          if (we && sel_set && idx == 2'(i)) begin
            set_q[i] <= hwdata;
          end
          if (we && sel_rst && idx == 2'(i)) begin
            rst_q[i] <= hwdata;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpi_q <= lsc_pkg::CPI_RESET;
      az_en_q <= 2'h0;
      irq_mask_q <= '0;
    end else begin
      if (we && sel_cpi) begin
        cpi_q <= hwdata;
      end
      if (we && sel_az) begin
        az_en_q <= hwdata[NC-1:0];
      end
      if (we && sel_imask) begin
        irq_mask_q <= hwdata[lsc_pkg::IRQ_W-1:0];
      end
    end
  end

  // Per-channel load, tare and auto-zero
  wire [NC-1:0] chan_err = ~sensor.calibrated | sensor.rating_zero | sensor.mvv_zero;
  wire signed [31:0] raw_load [NC];
  assign raw_load[0] = sample.load_a_raw;
  assign raw_load[1] = sample.load_b_raw;
  wire [NC-1:0] tare_wr = {we & sel_tare_b, we & sel_tare_a};

  generate
    for (genvar c = 0; c < NC; c++) begin : g_az
      logic near_q;
      logic signed [31:0] last_q;
      logic [31:0] cnt_q;
      wire near_now = (net_load[c] <= lsc_pkg::AZ_BAND) && (net_load[c] >= -lsc_pkg::AZ_BAND);
      assign net_load[c] = raw_load[c] - tare_q[c];
      assign az_fire[c] = az_en_q[c] & near_q & (cnt_q == 32'(AZ_CYCLES - 1));

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          near_q <= 1'b0;
          last_q <= 32'sh00000000;
          cnt_q <= 32'h00000000;
        end else if (az_fire[c]) begin
          // Wait for a fresh sample against the new tare
          near_q <= 1'b0;
          last_q <= 32'sh00000000;
          cnt_q <= 32'h00000000;
        end else begin
          if (sample_valid) begin
            near_q <= near_now;
            last_q <= net_load[c];
          end
          if (az_en_q[c] && near_q && !(sample_valid && !near_now)) begin
            cnt_q <= cnt_q + 32'h00000001;
          end else begin
            cnt_q <= 32'h00000000;
          end
        end
      end

      // Hardware tare wins over a software write in the same cycle
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          tare_q[c] <= lsc_pkg::TARE_RESET;
        end else if (az_fire[c]) begin
          tare_q[c] <= tare_q[c] + last_q;
        end else if (tare_wr[c]) begin
          tare_q[c] <= hwdata;
        end
      end
    end
  endgenerate

  wire signed [31:0] load_sum = net_load[0] + net_load[1];
  wire enc_err = cpi_q == 32'h00000000;

  // Limiters
  generate
    for (genvar i = 0; i < NL; i++) begin : g_lim
      lsc_pkg::lsc_cfg_t cfg;
      logic signed [31:0] val;
      logic src_err;
      assign cfg = lsc_pkg::lsc_cfg_t'(ctrl_q[i]);
      wire ch_err = cfg.chan_b ? chan_err[1] : chan_err[0];
      wire signed [31:0] ch_load = cfg.chan_b ? net_load[1] : net_load[0];

      // Source select, compared in the units software chose for set points
      assign val =
        (cfg.src == lsc_pkg::SRC_LOAD) ? ch_load :
        (cfg.src == lsc_pkg::SRC_PEAK) ? sample.peak :
        (cfg.src == lsc_pkg::SRC_VALLEY) ? sample.valley :
        (cfg.src == lsc_pkg::SRC_POS) ? sample.position :
        (cfg.src == lsc_pkg::SRC_VEL) ? sample.velocity :
        (cfg.src == lsc_pkg::SRC_GROSS) ? sample.gross :
        (cfg.src == lsc_pkg::SRC_SUM) ? load_sum :
        (cfg.src == lsc_pkg::SRC_POLY) ? sample.poly :
        sample.avg;

      // Unknown source codes count as a faulty source
      assign src_err =
        (cfg.src == lsc_pkg::SRC_POS || cfg.src == lsc_pkg::SRC_VEL) ? enc_err :
        (cfg.src == lsc_pkg::SRC_SUM) ? |chan_err :
        (cfg.src > lsc_pkg::SRC_AVG) ? 1'b1 :
        ch_err;

      wire above_set = val > set_q[i];
      wire below_set = val < set_q[i];
      wire set_c = cfg.trip_below ? below_set : above_set;
      wire rst_c = cfg.latch ? 1'b0 :
        cfg.trip_below ? (val > rst_q[i]) : (val < rst_q[i]);
      wire manual = cfg.latch & (reset_btn | cmd_clr[i]);

      always_comb begin
        if (!cfg.enable || src_err) begin
          act_d[i] = 1'b0;
        end else if (manual) begin
          act_d[i] = 1'b0;
        end else if (sample_valid && rst_c) begin
          act_d[i] = 1'b0;
        end else if (sample_valid && set_c) begin
          act_d[i] = 1'b1;
        end else begin
          act_d[i] = act_q[i];
        end
      end

      assign err_d[i] = cfg.enable & src_err;
      assign contact_d[i] = cfg.default_nc ^ act_d[i];
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q <= '0;
      err_q <= '0;
      contact_q <= 4'h0;
    end else begin
      act_q <= act_d;
      err_q <= err_d;
      contact_q <= contact_d;
    end
  end

  // Sticky events; a new event beats a same-cycle write-one-to-clear
  wire [lsc_pkg::IRQ_W-1:0] irq_ev = {az_fire, err_d & ~err_q, act_d & ~act_q};
  wire [lsc_pkg::IRQ_W-1:0] irq_w1c = (we && sel_istat) ? hwdata[lsc_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_ev;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign contact = contact_q;
  assign irq = irq_q;

endmodule

// *** tb_lsc_top.sv ***
`timescale 1ns/1ps
module tb_lsc_top;
  localparam int AZ = 20;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sample_valid = 0, reset_btn = 0, r;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rq;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, irq;
  logic [3:0] contact, closed_seen;
  wire logic hready = hreadyout;
  lsc_pkg::lsc_sample_t sample = '0;
  lsc_pkg::lsc_sensor_t sensor = 6'h30;
  int err_total = 0, num_checks = 0;
  lsc_top #(.AZ_CYCLES(AZ)) i_lsc_top (.*);
  lsc_relay i_lsc_relay (.*);
  initial begin
    forever #10 hclk = ~hclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Ready is looked at between edges, so the flop update cannot race us
  task wt;
    do begin
      @(negedge hclk);
      r = hreadyout;
      rq = hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    repeat (2) @(posedge hclk);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rq, exp);
  endtask
  task smp(input logic [31:0] v);
    sample <= {9{v}};
    sample_valid <= 1'b1;
    @(posedge hclk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  task t_regs;
    rc(lsc_pkg::ADDR_CPI, 32'h5dc0);
    rc(lsc_pkg::ADDR_CTRL0, 32'h0);
    rc(8'h50, 32'h0);
    wr(lsc_pkg::ADDR_CMD, 32'h1);
    rc(lsc_pkg::ADDR_CMD, 32'h0);
    chk(contact, 4'h0);
  endtask
  task t_above;
    wr(lsc_pkg::ADDR_IRQ_MASK, 32'h1);
    wr(lsc_pkg::ADDR_SET0, 32'd100);
    wr(lsc_pkg::ADDR_RST0, 32'd50);
    wr(lsc_pkg::ADDR_CTRL0, 32'h22);
    smp(32'd101);
    chk(contact[0], 1'b1);
    chk(irq, 1'b1);
    smp(32'd100);
    chk(contact[0], 1'b1);
    smp(32'd49);
    chk(contact[0], 1'b0);
    chk(closed_seen[0], 1'b1);
    wr(lsc_pkg::ADDR_IRQ_STAT, 32'h1);
    rc(lsc_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(irq, 1'b0);
    wr(lsc_pkg::ADDR_CTRL0, 32'h0);
  endtask
  task t_below;
    wr(lsc_pkg::ADDR_SET0 + 8'h4, 32'hfffffff6);
    wr(lsc_pkg::ADDR_RST0 + 8'h4, 32'h0);
    wr(lsc_pkg::ADDR_CTRL0 + 8'h4, 32'h47);
    chk(contact[1], 1'b1);
    smp(32'hfffffff5);
    chk(contact[1], 1'b0);
    smp(32'h0);
    chk(contact[1], 1'b0);
    smp(32'h1);
    chk(contact[1], 1'b1);
    wr(lsc_pkg::ADDR_CTRL0 + 8'h4, 32'h0);
  endtask
  task t_latch;
    wr(lsc_pkg::ADDR_SET0 + 8'h8, 32'd10);
    wr(lsc_pkg::ADDR_RST0 + 8'h8, 32'd1000);
    wr(lsc_pkg::ADDR_CTRL0 + 8'h8, 32'haa);
    smp(32'd11);
    smp(32'd0);
    chk(contact[2], 1'b1);
    reset_btn <= 1'b1;
    @(posedge hclk);
    reset_btn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(contact[2], 1'b0);
    smp(32'd11);
    chk(contact[2], 1'b1);
    wr(lsc_pkg::ADDR_CMD, 32'h4);
    chk(contact[2], 1'b0);
    wr(lsc_pkg::ADDR_CTRL0 + 8'h8, 32'h0);
  endtask
  task t_both;
    wr(lsc_pkg::ADDR_SET0 + 8'hc, 32'd10);
    wr(lsc_pkg::ADDR_RST0 + 8'hc, 32'd20);
    wr(lsc_pkg::ADDR_CTRL0 + 8'hc, 32'he2);
    smp(32'd15);
    chk(contact[3], 1'b0);
    smp(32'd25);
    chk(contact[3], 1'b1);
    wr(lsc_pkg::ADDR_CTRL0 + 8'hc, 32'h0);
  endtask
  task t_err;
    wr(lsc_pkg::ADDR_CTRL0, 32'h2);
    smp(32'd150);
    chk(contact[0], 1'b1);
    sensor <= 6'h20;
    repeat (3) @(posedge hclk);
    chk(contact[0], 1'b0);
    rc(lsc_pkg::ADDR_STATUS, 32'h10);
    sensor <= 6'h30;
    rc(lsc_pkg::ADDR_STATUS, 32'h0);
    sensor <= 6'h34;
    rc(lsc_pkg::ADDR_STATUS, 32'h10);
    sensor <= 6'h30;
    rc(lsc_pkg::ADDR_STATUS, 32'h0);
    sensor <= 6'h31;
    rc(lsc_pkg::ADDR_STATUS, 32'h10);
    sensor <= 6'h30;
    wr(lsc_pkg::ADDR_CTRL0, 32'h0);
    wr(lsc_pkg::ADDR_CTRL0 + 8'hc, 32'h62);
    wr(lsc_pkg::ADDR_CPI, 32'h0);
    rc(lsc_pkg::ADDR_STATUS, 32'h80);
    wr(lsc_pkg::ADDR_CPI, 32'h5dc0);
    wr(lsc_pkg::ADDR_CTRL0 + 8'hc, 32'h0);
  endtask
  task t_dis;
    wr(lsc_pkg::ADDR_CTRL0, 32'h0d);
    smp(32'hfffffc18);
    chk(contact[0], 1'b1);
    wr(lsc_pkg::ADDR_CTRL0, 32'h0);
  endtask
  // Sum, unknown code, channel B pick and velocity error sources
  task t_src;
    wr(lsc_pkg::ADDR_CTRL0, 32'hc2);
    smp(32'd60);
    chk(contact[0], 1'b1);
    smp(32'd20);
    chk(contact[0], 1'b0);
    wr(lsc_pkg::ADDR_CTRL0, 32'h122);
    rc(lsc_pkg::ADDR_STATUS, 32'h10);
    sensor <= 6'h20;
    wr(lsc_pkg::ADDR_CTRL0, 32'h112);
    rc(lsc_pkg::ADDR_STATUS, 32'h0);
    wr(lsc_pkg::ADDR_CTRL0, 32'h82);
    rc(lsc_pkg::ADDR_STATUS, 32'h0);
    wr(lsc_pkg::ADDR_CPI, 32'h0);
    rc(lsc_pkg::ADDR_STATUS, 32'h10);
    wr(lsc_pkg::ADDR_CPI, 32'h5dc0);
    sensor <= 6'h30;
    wr(lsc_pkg::ADDR_CTRL0, 32'h0);
  endtask
  // Auto-zero hold shortened through the parameter; band edge is 10
  task t_az;
    wr(lsc_pkg::ADDR_IRQ_STAT, 32'h3ff);
    wr(lsc_pkg::ADDR_AZ_EN, 32'h1);
    smp(32'd5);
    repeat (AZ + 5) @(posedge hclk);
    rc(lsc_pkg::ADDR_TARE_A, 32'd5);
    rc(lsc_pkg::ADDR_TARE_B, 32'd0);
    rc(lsc_pkg::ADDR_IRQ_STAT, 32'h100);
    smp(32'd16);
    repeat (AZ + 5) @(posedge hclk);
    rc(lsc_pkg::ADDR_TARE_A, 32'd5);
    smp(32'd15);
    repeat (AZ + 5) @(posedge hclk);
    rc(lsc_pkg::ADDR_TARE_A, 32'd15);
    wr(lsc_pkg::ADDR_AZ_EN, 32'h0);
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_above();
    t_below();
    t_latch();
    t_both();
    t_err();
    t_dis();
    t_src();
    t_az();
    results();
  end
  initial begin
    repeat (5000) @(posedge hclk);
    err_total++;
    results();
  end
endmodule
